/* File: core/hotswap_oring_sequencer.sv */
// Supervisory sequencer for a hot-swap FET and an ORing FET
// Overview of operation
// (RULE1) Fast trip gives 63 us strong pulldown
// (RULE2) Immediate variant latches; others restart surge
// (RULE3) Latch variant restarts once, then stays off
// (RULE4) Retry variant retries; timer tie sets duty
// (RULE5) Retry cycles surge timer 64 times
// (RULE6) Startup waits 1.9 ms after hot-swap enable
// (RULE7) Hot-swap inhibited while pump not up
// (RULE8) Surge mode regulates; expiry latches or retries
// (RULE9) Regular mode: timers cleared, gate high
// (RULE10) Fault mode runs fault timer
// (RULE11) Latched exits only on enable rising edge or pump down
// (RULE12) Power good sets after 1 ms
// (RULE13) Power good clears after 8 ms
// (RULE14) Fault flag on short, timeout, open, heat
// (RULE15) Fault flag when pump down beyond 32 ms
// (RULE16) Precharge below 3.7 V, leave above 5.5 V
// (RULE17) FET on: 20 us fast pull-up, then weak
// (RULE18) Reverse: 15 us strong pulldown, then weak
// (RULE19) Status shows ORing gate on or off
// (RULE20) Excess supply turns both FETs off
// (RULE21) Either timer at threshold is timeout
// (RULE22) Timers are up/down counters with terminals
`timescale 1ns/1ps
module hotswap_oring_sequencer #(
   parameter int TRIP_CYC      = hotswap_oring_pkg::TRIP_PULSE_CYC,
   parameter int START_CYC     = hotswap_oring_pkg::START_WAIT_CYC,
   parameter int PG_ON_CYC     = hotswap_oring_pkg::PG_ON_CYC,
   parameter int PG_OFF_CYC    = hotswap_oring_pkg::PG_OFF_CYC,
   parameter int PUMP_DOWN_CYC = hotswap_oring_pkg::PUMP_DOWN_CYC
) (
   // Clock and reset
   input  wire logic                               i_clk,
   input  wire logic                               i_rst,
   // Enables and comparator pins
   input  wire logic                               i_hotswap_enable_in,
   input  wire logic                               i_oring_enable_in,
   input  wire logic                               i_pump_above_hi,
   input  wire logic                               i_pump_below_lo,
   input  wire logic                               i_fwd_drop_on,
   input  wire logic                               i_fwd_drop_open,
   input  wire logic                               i_reverse_sense_pos_gt_neg,
   input  wire logic                               i_excess_supply_trip,
   input  wire logic                               i_overtemp_shutdown,
   input  wire logic                               i_current_sense_shorted,
   input  wire logic                               i_vds_low,
   input  wire logic                               i_vds_high,
   input  wire logic                               i_over_current,
   input  wire logic                               i_fast_trip,
   input  wire logic                               i_limiting,
   // Configuration
   input  wire hotswap_oring_pkg::trip_variant_t   i_trip_variant,
   input  wire logic                               i_timers_tied,
   input  wire logic [hotswap_oring_pkg::TIMER_W-1:0] i_surge_term,
   input  wire logic [hotswap_oring_pkg::TIMER_W-1:0] i_fault_term,
   // Hot-swap gate drive
   output logic                                    o_hotswap_gate_regulate,
   output logic                                    o_hotswap_gate_high,
   output logic                                    o_hotswap_gate_strong_pd,
   output logic                                    o_hotswap_gate_pd,
   // ORing gate drive
   output logic                                    o_oring_gate_fast_pu,
   output logic                                    o_oring_gate_weak_pu,
   output logic                                    o_oring_gate_strong_pd,
   output logic                                    o_oring_gate_weak_pd,
   // Flags
   output logic                                    o_oring_on_status,
   output logic                                    o_power_good_out,
   output logic                                    o_fault_n_out
);
   import hotswap_oring_pkg::*;

   logic [PIN_N-1:0]   sync1_ff;
   logic [PIN_N-1:0]   sync2_ff;
   logic               en_hs;
   logic               en_or;
   logic               pump_hi;
   logic               pump_lo;
   logic               fwd_on;
   logic               fwd_open;
   logic               reverse;
   logic               excess;
   logic               overtemp;
   logic               shorted;
   logic               vds_low;
   logic               vds_high;
   logic               over_cur;
   logic               fast_trip;
   logic               limiting;
   oring_state_t       or_state_ff;
   oring_state_t       nxt_or_state;
   hs_state_t          hs_state_ff;
   hs_state_t          nxt_hs_state;
   hs_state_t          fail_state;
   logic [CNT_W-1:0]   start_cnt_ff;
   logic [CNT_W-1:0]   trip_cnt_ff;
   logic [CNT_W-1:0]   boost_cnt_ff;
   logic [CNT_W-1:0]   pg_cnt_ff;
   logic [CNT_W-1:0]   pump_dn_cnt_ff;
   logic [RETRY_W-1:0] retry_cnt_ff;
   logic               retry_up_ff;
   logic               restart_used_ff;
   logic               timeout_ff;
   logic               en_hs_d_ff;
   logic               from_on_ff;
   logic               pg_ff;
   logic               fault_n_ff;
   logic               pump_up;
   logic               hs_rise;
   logic               timeout;
   logic               trip_done;
   logic               surge_exp;
   logic               surge_empty;
   logic               fault_exp;
   logic               fault_empty;
   logic               surge_charge;
   logic               fault_charge;
   logic               surge_clear;
   logic               fault_clear;
   logic               pg_flip;
   logic               pump_dn_long;

   // Every enable and comparator pin is asynchronous to the clock
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= {i_hotswap_enable_in, i_oring_enable_in, i_pump_above_hi,
                      i_pump_below_lo, i_fwd_drop_on, i_fwd_drop_open,
                      i_reverse_sense_pos_gt_neg, i_excess_supply_trip,
                      i_overtemp_shutdown, i_current_sense_shorted, i_vds_low,
                      i_vds_high, i_over_current, i_fast_trip, i_limiting};
         sync2_ff <= sync1_ff;
      end
   end

   assign {en_hs, en_or, pump_hi, pump_lo, fwd_on, fwd_open, reverse, excess,
           overtemp, shorted, vds_low, vds_high, over_cur, fast_trip,
           limiting} = sync2_ff;

   assign pump_up   = (or_state_ff != OR_PRE);
   assign hs_rise   = en_hs && !en_hs_d_ff;
   assign timeout   = surge_exp || fault_exp; // RULE21
   assign trip_done = (trip_cnt_ff == CNT_W'(TRIP_CYC - 1));
   assign fail_state = (i_trip_variant == VAR_RETRY) ? HS_RETRY : HS_LATCH;

   // ORing machine
   always_comb begin
      nxt_or_state = or_state_ff;
      if (pump_lo) begin
         nxt_or_state = OR_PRE; // RULE16
      end else begin
         case (or_state_ff)
            OR_PRE: if (pump_hi) nxt_or_state = OR_OFF; // RULE16
            OR_OFF: if (en_or && fwd_on) nxt_or_state = OR_ON; // RULE17
            OR_ON:  if (reverse || !en_or) nxt_or_state = OR_OFF; // RULE18
            default: nxt_or_state = OR_PRE;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         or_state_ff <= OR_PRE; // RULE16
      end else begin
         or_state_ff <= nxt_or_state;
      end
   end

   // Boost timing restarts on every ORing state change
   always_ff @(posedge i_clk) begin
      if (i_rst || nxt_or_state != or_state_ff) begin
         boost_cnt_ff <= '0;
      end else if (boost_cnt_ff < CNT_W'(BOOST_UP_CYC)) begin
         boost_cnt_ff <= boost_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         from_on_ff <= 1'b0;
      end else if (nxt_or_state != or_state_ff) begin
         from_on_ff <= (or_state_ff == OR_ON);
      end
   end

   // Hot-swap machine
   always_comb begin
      nxt_hs_state = hs_state_ff;
      if (!pump_up) begin
         nxt_hs_state = HS_WAIT; // RULE7
      end else begin
         case (hs_state_ff)
            HS_WAIT: begin
               if (en_hs && start_cnt_ff == CNT_W'(START_CYC - 1)) begin
                  nxt_hs_state = HS_SURGE; // RULE6
               end
            end
            HS_SURGE: begin
               if (!en_hs) nxt_hs_state = HS_WAIT;
               else if (timeout) nxt_hs_state = fail_state; // RULE8
               else if (!limiting && vds_low) nxt_hs_state = HS_REG;
            end
            HS_REG: begin
               if (!en_hs) nxt_hs_state = HS_WAIT;
               else if (fast_trip) nxt_hs_state = HS_TRIP; // RULE1
               else if (over_cur) nxt_hs_state = HS_FAULT; // RULE9
            end
            HS_FAULT: begin
               if (!en_hs) nxt_hs_state = HS_WAIT;
               else if (fast_trip) nxt_hs_state = HS_TRIP;
               else if (timeout) nxt_hs_state = fail_state; // RULE10
               else if (!over_cur) nxt_hs_state = HS_REG; // RULE10
            end
            HS_TRIP: begin
               if (trip_done) begin
                  if (i_trip_variant == VAR_IMMEDIATE) nxt_hs_state = HS_LATCH; // RULE2
                  else if (i_trip_variant == VAR_LATCH && restart_used_ff)
                     nxt_hs_state = HS_LATCH; // RULE3
                  else nxt_hs_state = HS_SURGE; // RULE2
               end
            end
            HS_LATCH: if (hs_rise) nxt_hs_state = HS_SURGE; // RULE11
            HS_RETRY: begin
               if (!en_hs) nxt_hs_state = HS_WAIT;
               else if (retry_cnt_ff == RETRY_W'(RETRY_CYCLES - 1) && !retry_up_ff
                        && surge_empty) nxt_hs_state = HS_SURGE; // RULE5
            end
            default: nxt_hs_state = HS_WAIT;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         hs_state_ff <= HS_WAIT;
      end else begin
         hs_state_ff <= nxt_hs_state;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || hs_state_ff != HS_WAIT || !en_hs) begin
         start_cnt_ff <= '0;
      end else if (start_cnt_ff != CNT_W'(START_CYC - 1)) begin
         start_cnt_ff <= start_cnt_ff + 1'b1; // RULE6
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || hs_state_ff != HS_TRIP) begin
         trip_cnt_ff <= '0;
      end else if (!trip_done) begin
         trip_cnt_ff <= trip_cnt_ff + 1'b1; // RULE1
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         en_hs_d_ff <= 1'b0;
      end else begin
         en_hs_d_ff <= en_hs;
      end
   end

   // Set wins over the enable edge that clears it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         restart_used_ff <= 1'b0;
      end else if (hs_state_ff == HS_TRIP && nxt_hs_state == HS_SURGE
                   && i_trip_variant == VAR_LATCH) begin
         restart_used_ff <= 1'b1; // RULE3
      end else if (hs_state_ff == HS_LATCH && hs_rise) begin
         restart_used_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         timeout_ff <= 1'b0;
      end else if ((hs_state_ff == HS_SURGE || (hs_state_ff == HS_FAULT && !fast_trip))
                   && pump_up && en_hs && timeout) begin
         timeout_ff <= 1'b1;
      end else if (hs_rise) begin
         timeout_ff <= 1'b0;
      end
   end

   // Retry: full charge and discharge of the surge timer per cycle
   always_ff @(posedge i_clk) begin
      if (i_rst || hs_state_ff != HS_RETRY) begin
         retry_up_ff  <= 1'b1;
         retry_cnt_ff <= '0;
      end else if (retry_up_ff && surge_exp) begin
         retry_up_ff <= 1'b0; // RULE5
      end else if (!retry_up_ff && surge_empty
                   && retry_cnt_ff != RETRY_W'(RETRY_CYCLES - 1)) begin
         retry_up_ff  <= 1'b1;
         retry_cnt_ff <= retry_cnt_ff + 1'b1; // RULE5
      end
   end

   // Tied timers share one capacitor, so both see the same charge
   always_comb begin
      surge_charge = (hs_state_ff == HS_SURGE && limiting)
                     || (hs_state_ff == HS_RETRY && retry_up_ff); // RULE8
      fault_charge = (hs_state_ff == HS_FAULT); // RULE10
      if (i_timers_tied) begin
         surge_charge = surge_charge || fault_charge; // RULE4
         fault_charge = surge_charge;
      end
      surge_clear = hs_state_ff == HS_REG || hs_state_ff == HS_WAIT
                    || (hs_state_ff == HS_LATCH && hs_rise); // RULE9 RULE11
      fault_clear = surge_clear;
   end

   updown_timer #(.W(TIMER_W)) u_surge_timer (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_charge  (surge_charge),
      .i_clear   (surge_clear),
      .i_slow    (!i_timers_tied), // RULE4
      .i_term    (i_surge_term),
      .o_expired (surge_exp),
      .o_empty   (surge_empty)
   );

   updown_timer #(.W(TIMER_W)) u_fault_timer (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_charge  (fault_charge),
      .i_clear   (fault_clear),
      .i_slow    (!i_timers_tied),
      .i_term    (i_fault_term),
      .o_expired (fault_exp),
      .o_empty   (fault_empty)
   );

   // Power good deglitch: count only while the flipping condition holds
   assign pg_flip = pg_ff ? (!en_hs || vds_high || timeout_ff) // RULE13
                          : (en_hs && vds_low); // RULE12

   always_ff @(posedge i_clk) begin
      if (i_rst || !pg_flip) begin
         pg_cnt_ff <= '0;
         pg_ff     <= i_rst ? RST_PG : pg_ff;
      end else if (pg_cnt_ff == CNT_W'((pg_ff ? PG_OFF_CYC : PG_ON_CYC) - 1)) begin
         pg_cnt_ff <= '0;
         pg_ff     <= ~pg_ff; // RULE12 RULE13
      end else begin
         pg_cnt_ff <= pg_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || pump_up) begin
         pump_dn_cnt_ff <= '0;
      end else if (!pump_dn_long) begin
         pump_dn_cnt_ff <= pump_dn_cnt_ff + 1'b1; // RULE15
      end
   end

   assign pump_dn_long = (pump_dn_cnt_ff == CNT_W'(PUMP_DOWN_CYC));

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fault_n_ff <= RST_FAULT_N;
      end else begin
         fault_n_ff <= !((!en_hs && shorted) || timeout_ff || hs_state_ff == HS_LATCH
                         || (en_or && pump_up && fwd_open) // RULE14
                         || pump_dn_long || overtemp); // RULE15
      end
   end

   // Gate drive, with excess supply overriding every state
   assign o_hotswap_gate_regulate  = hs_state_ff == HS_SURGE && !excess; // RULE8 RULE20
   assign o_hotswap_gate_high      = (hs_state_ff == HS_REG || hs_state_ff == HS_FAULT)
                                     && !excess; // RULE9 RULE20
   assign o_hotswap_gate_strong_pd = hs_state_ff == HS_TRIP; // RULE1
   assign o_hotswap_gate_pd        = !o_hotswap_gate_regulate && !o_hotswap_gate_high;
   assign o_oring_gate_fast_pu     = or_state_ff == OR_ON && !excess
                                     && boost_cnt_ff < CNT_W'(BOOST_UP_CYC); // RULE17
   assign o_oring_gate_weak_pu     = or_state_ff == OR_ON && !excess
                                     && !o_oring_gate_fast_pu; // RULE17
   assign o_oring_gate_strong_pd   = or_state_ff == OR_OFF && from_on_ff
                                     && boost_cnt_ff < CNT_W'(BOOST_DN_CYC); // RULE18
   assign o_oring_gate_weak_pd     = !o_oring_gate_fast_pu && !o_oring_gate_weak_pu
                                     && !o_oring_gate_strong_pd; // RULE18 RULE20
   assign o_oring_on_status        = or_state_ff == OR_ON && !excess; // RULE19
   assign o_power_good_out         = pg_ff;
   assign o_fault_n_out            = fault_n_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence trip_entry_s;
      hs_state_ff == HS_REG && pump_up && en_hs && fast_trip;
   endsequence

   sequence trip_end_s;
      hs_state_ff == HS_TRIP && trip_done && pump_up;
   endsequence

   trip_pulse_a: assert property ( // RULE1
      trip_entry_s |=> hs_state_ff == HS_TRIP && o_hotswap_gate_strong_pd)
      else $error("fast trip did not start pulldown");
   trip_length_a: assert property ( // RULE1
      ($fell(hs_state_ff == HS_TRIP) && $past(pump_up))
      |-> $past(trip_cnt_ff) == CNT_W'(TRIP_CYC - 1))
      else $error("trip pulse length wrong");
   immediate_latch_a: assert property ( // RULE2
      (trip_end_s and i_trip_variant == VAR_IMMEDIATE) |=> hs_state_ff == HS_LATCH)
      else $error("immediate variant did not latch");
   one_restart_a: assert property ( // RULE3
      (trip_end_s and i_trip_variant == VAR_LATCH and restart_used_ff)
      |=> hs_state_ff == HS_LATCH)
      else $error("latch variant restarted twice");
   retry_count_a: assert property ( // RULE5
      (hs_state_ff == HS_RETRY ##1 hs_state_ff == HS_SURGE)
      |-> $past(retry_cnt_ff) == RETRY_W'(RETRY_CYCLES - 1))
      else $error("retry left early");
   pump_inhibit_a: assert property ( // RULE7
      or_state_ff == OR_PRE |=> hs_state_ff == HS_WAIT)
      else $error("hot-swap ran without pump");
   reg_timers_a: assert property ( // RULE9
      (hs_state_ff == HS_REG ##1 hs_state_ff == HS_REG) |-> surge_empty && fault_empty)
      else $error("timers not discharged in regular mode");
   latch_hold_a: assert property ( // RULE11
      hs_state_ff == HS_LATCH [*2] |-> !o_hotswap_gate_high && !o_fault_n_out)
      else $error("latched mode gate or fault wrong");
   precharge_a: assert property ( // RULE16
      pump_lo |=> or_state_ff == OR_PRE)
      else $error("pump low did not precharge");
   boost_up_a: assert property ( // RULE17
      ($rose(or_state_ff == OR_ON) && !excess) |-> o_oring_gate_fast_pu)
      else $error("no fast pull-up on FET on");
   excess_off_a: assert property ( // RULE20
      excess |-> !o_hotswap_gate_high && !o_hotswap_gate_regulate
                 && !o_oring_gate_weak_pu && !o_oring_on_status)
      else $error("excess supply left a FET on");
   overtemp_flag_a: assert property ( // RULE14
      overtemp |=> !o_fault_n_out)
      else $error("overtemp did not flag fault");
endmodule : hotswap_oring_sequencer

/* File: core/hotswap_oring_pkg.sv */
// Shared constants and types of the hot-swap and ORing sequencer
package hotswap_oring_pkg;
   localparam int CLK_MHZ       = 200;
   // Times in microseconds
   localparam int TRIP_PULSE_US = 63;
   localparam int BOOST_UP_US   = 20;
   localparam int BOOST_DN_US   = 15;
   localparam int START_WAIT_US = 1900;
   localparam int PG_ON_US      = 1000;
   localparam int PG_OFF_US     = 8000;
   localparam int PUMP_DOWN_US  = 32000;
   // Cycle counts
   localparam int TRIP_PULSE_CYC = TRIP_PULSE_US * CLK_MHZ;
   localparam int BOOST_UP_CYC   = BOOST_UP_US * CLK_MHZ;
   localparam int BOOST_DN_CYC   = BOOST_DN_US * CLK_MHZ;
   localparam int START_WAIT_CYC = START_WAIT_US * CLK_MHZ;
   localparam int PG_ON_CYC      = PG_ON_US * CLK_MHZ;
   localparam int PG_OFF_CYC     = PG_OFF_US * CLK_MHZ;
   localparam int PUMP_DOWN_CYC  = PUMP_DOWN_US * CLK_MHZ;
   localparam int RETRY_CYCLES   = 64;
   localparam int CNT_W          = 24;
   localparam int RETRY_W        = 7;
   localparam int TIMER_W        = 16;
   localparam int PIN_N          = 15;
   // Reset values
   localparam logic RST_PG      = 1'b0;
   localparam logic RST_FAULT_N = 1'b1;

   typedef enum logic [1:0] {
      OR_PRE = 2'b00,
      OR_OFF = 2'b01,
      OR_ON  = 2'b10
   } oring_state_t;

   typedef enum logic [2:0] {
      HS_WAIT  = 3'b000,
      HS_SURGE = 3'b001,
      HS_REG   = 3'b010,
      HS_FAULT = 3'b011,
      HS_TRIP  = 3'b100,
      HS_LATCH = 3'b101,
      HS_RETRY = 3'b110
   } hs_state_t;

   typedef enum logic [1:0] {
      VAR_LATCH     = 2'b00,
      VAR_RETRY     = 2'b01,
      VAR_IMMEDIATE = 2'b10
   } trip_variant_t;
endpackage : hotswap_oring_pkg

/* File: core/updown_timer.sv */
// Up/down counter standing in for a capacitor timer
`timescale 1ns/1ps
module updown_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Control
   input  wire logic         i_charge,
   input  wire logic         i_clear,
   input  wire logic         i_slow,
   input  wire logic [W-1:0] i_term,
   // Status
   output logic              o_expired,
   output logic              o_empty
);
   logic [W-1:0] count_ff;
   logic         half_ff;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         half_ff <= 1'b0;
      end else begin
         half_ff <= ~half_ff;
      end
   end

   // Slow discharge halves the sink rate, stretching the off time
   always_ff @(posedge i_clk) begin
      if (i_rst || i_clear) begin
         count_ff <= '0;
      end else if (i_charge) begin
         if (count_ff < i_term) begin
            count_ff <= count_ff + 1'b1; // RULE22
         end
      end else if (count_ff != '0 && (!i_slow || half_ff)) begin
         count_ff <= count_ff - 1'b1; // RULE22
      end
   end

   assign o_expired = (count_ff >= i_term);
   assign o_empty   = (count_ff == '0);
endmodule : updown_timer

/* File: test/fet_model.sv */
// Behavioural pass FETs and comparators on the far side
`timescale 1ns/1ps
module fet_model (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Gate drives seen
   input  wire logic i_src_up,
   input  wire logic i_hs_on,
   input  wire logic i_or_on,
   // Comparator levels
   output logic      o_vds_low,
   output logic      o_vds_high,
   output logic      o_fwd_drop_on
);
   // One cycle of lag stands in for gate slew
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_vds_low     <= 1'b0;
         o_vds_high    <= 1'b1;
         o_fwd_drop_on <= 1'b0;
      end else begin
         o_vds_low     <= i_hs_on;
         o_vds_high    <= !i_hs_on;
         o_fwd_drop_on <= i_src_up && !i_or_on;
      end
   end
endmodule : fet_model

/* File: test/tb_top.sv */
// Self-checking bench of the hot-swap and ORing sequencer
`timescale 1ns/1ps
module tb_top;
   import hotswap_oring_pkg::*;
   logic i_clk, i_rst, en_hs, en_or, up_hi, rev, exc, oc, trip, src, vl, vh, fwd;
   logic reg_o, high_o, spd_o, pd_o, fpu_o, wpu_o, ospd_o, wpd_o, stat_o, pg_o, flt_o;
   int error_cnt, checks, cyc, n;
   logic lo, opn, hot, sh, lim;
   trip_variant_t var_s;
   hotswap_oring_sequencer #(.TRIP_CYC(20), .START_CYC(30), .PG_ON_CYC(10),
      .PG_OFF_CYC(40), .PUMP_DOWN_CYC(50)) hotswap_oring_sequencer_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_hotswap_enable_in(en_hs),
      .i_oring_enable_in(en_or), .i_pump_above_hi(up_hi), .i_pump_below_lo(lo),
      .i_fwd_drop_on(fwd), .i_fwd_drop_open(opn), .i_reverse_sense_pos_gt_neg(rev),
      .i_excess_supply_trip(exc), .i_overtemp_shutdown(hot),
      .i_current_sense_shorted(sh), .i_vds_low(vl), .i_vds_high(vh),
      .i_over_current(oc), .i_fast_trip(trip), .i_limiting(lim),
      .i_trip_variant(var_s), .i_timers_tied(1'b1), .i_surge_term(16'h0010),
      .i_fault_term(16'h0010), .o_hotswap_gate_regulate(reg_o),
      .o_hotswap_gate_high(high_o), .o_hotswap_gate_strong_pd(spd_o),
      .o_hotswap_gate_pd(pd_o), .o_oring_gate_fast_pu(fpu_o), .o_oring_gate_weak_pu(wpu_o),
      .o_oring_gate_strong_pd(ospd_o), .o_oring_gate_weak_pd(wpd_o),
      .o_oring_on_status(stat_o), .o_power_good_out(pg_o), .o_fault_n_out(flt_o));
   fet_model fet_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_src_up(src),
      .i_hs_on(high_o || reg_o), .i_or_on(stat_o), .o_vds_low(vl), .o_vds_high(vh),
      .o_fwd_drop_on(fwd));
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic report_and_stop;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic sel(input int k);
      case (k)
         0: sel = reg_o;
         1: sel = high_o;
         2: sel = spd_o;
         3: sel = pg_o;
         4: sel = !pg_o;
         5: sel = !flt_o;
         6: sel = stat_o;
         7: sel = ospd_o;
         8: sel = flt_o;
         default: sel = pd_o;
      endcase
   endfunction : sel
   // Bounded wait; n returns cycles spent
   task automatic wait_hi(input int k, input int lim, output int cnt);
      cnt = 0;
      while (sel(k) !== 1'b1 && cnt < lim) begin
         @(posedge i_clk);
         #1;
         cnt++;
      end
      chk(sel(k), 1'b1);
   endtask : wait_hi
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      {en_hs, en_or, up_hi, rev, exc, oc, trip, src} = '0;
      {lo, opn, hot, sh, lim} = '0;
      var_s = VAR_IMMEDIATE;
      i_rst = 1'b1;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      chk({flt_o, pg_o, stat_o, pd_o}, 4'h9);
      wait_hi(5, 60, n);
      chk(n > 49, 1'b1);
      @(posedge i_clk);
      {up_hi, en_or, src} <= 3'b111;
      wait_hi(6, 20, n);
      chk({fpu_o, wpu_o}, 2'h2);
      // Shorted FET, overtemp and open ORing FET each pull the flag
      for (int i = 0; i < 3; i++) begin
         @(posedge i_clk);
         {sh, hot, opn} <= 3'b100 >> i;
         wait_hi(5, 6, n);
         {sh, hot, opn} <= 3'b000;
         wait_hi(8, 6, n);
      end
      @(posedge i_clk);
      en_hs <= 1'b1;
      wait_hi(0, 60, n);
      chk(n > 29, 1'b1);
      wait_hi(1, 20, n);
      wait_hi(3, 30, n);
      chk(n > 8, 1'b1);
      @(posedge i_clk);
      trip <= 1'b1;
      wait_hi(2, 10, n);
      trip <= 1'b0;
      n = 0;
      while (spd_o === 1'b1 && n < 100) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk(n > 18 && n < 22, 1'b1);
      repeat (3) @(posedge i_clk);
      #1;
      chk({flt_o, pd_o, reg_o}, 3'h2);
      en_hs <= 1'b0;
      repeat (4) @(posedge i_clk);
      en_hs <= 1'b1;
      wait_hi(0, 20, n);
      wait_hi(1, 20, n);
      @(posedge i_clk);
      oc <= 1'b1;
      wait_hi(5, 60, n);
      chk(n > 15, 1'b1);
      chk(pd_o, 1'b1);
      wait_hi(4, 80, n);
      chk(n > 30, 1'b1);
      exc <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      chk({stat_o, fpu_o, wpu_o}, 3'h0);
      exc <= 1'b0;
      repeat (4) @(posedge i_clk);
      rev <= 1'b1;
      wait_hi(7, 10, n);
      chk({stat_o, wpd_o}, 2'h0);
      {rev, oc} <= 2'b00;
      var_s <= VAR_LATCH;
      en_hs <= 1'b0;
      repeat (4) @(posedge i_clk);
      en_hs <= 1'b1;
      // Latch variant: first trip restarts, second one stays off
      for (int i = 0; i < 2; i++) begin
         wait_hi(1, 20, n);
         @(posedge i_clk);
         trip <= 1'b1;
         wait_hi(2, 10, n);
         trip <= 1'b0;
         repeat (26) @(posedge i_clk);
         #1;
         chk({flt_o, high_o}, i ? 2'h0 : 2'h3);
      end
      var_s <= VAR_RETRY;
      lim <= 1'b1;
      en_hs <= 1'b0;
      repeat (4) @(posedge i_clk);
      en_hs <= 1'b1;
      wait_hi(0, 20, n);
      wait_hi(9, 30, n);
      chk(n > 15, 1'b1);
      lim <= 1'b0;
      wait_hi(0, 2300, n);
      chk(n > 2015, 1'b1);
      chk(flt_o, 1'b0);
      lo <= 1'b1;
      repeat (5) @(posedge i_clk);
      #1;
      chk(stat_o, 1'b0);
      chk({reg_o, high_o}, 2'h0);
      report_and_stop();
   end
endmodule : tb_top
